//--- logic/cond_select_pkg.sv
// package: condition field layout, apb offsets, encodings and carriers
package cond_select_pkg;
  // flag positions within a 4-bit field (bit 00 is msb of the field)
  localparam logic [1:0] FLAG_LESS = 2'h0;
  localparam logic [1:0] FLAG_GREATER = 2'h1;
  localparam logic [1:0] FLAG_ZERO = 2'h2;
  localparam logic [1:0] FLAG_OVER = 2'h3;
  localparam logic [2:0] FIELD_INT = 3'h0;
  localparam logic [2:0] FIELD_FLOAT = 3'h1;
  localparam logic [6:0] ARCH_BIT_OFFSET = 7'h20;
  localparam logic [31:0] COND_RESET = 32'h0000_0000;
  // branch options bit positions, bit 4 is the msb of the 5-bit field
  localparam int OPT_IGNORE = 4;
  localparam int OPT_SENSE = 3;
  localparam int OPT_A = 1;
  localparam int OPT_T = 0;
  localparam logic [1:0] HINT_NONE = 2'h0;
  localparam logic [1:0] HINT_NOT_TAKEN = 2'h2;
  localparam logic [1:0] HINT_TAKEN = 2'h3;
  // apb register byte offsets
  localparam logic [7:0] ADDR_COND = 8'h00;
  localparam logic [7:0] ADDR_SUMMARY = 8'h04;
  localparam logic [7:0] ADDR_LAST = 8'h08;

  typedef enum logic [3:0] {
    OP_NONE = 4'h1,
    OP_INT_REC = 4'h2,
    OP_CMP = 4'h4,
    OP_OTHER = 4'h8
  } update_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACCESS = 3'h2,
    ST_DONE = 3'h4
  } apb_state_t;

  typedef struct packed {
    logic valid;
    logic [4:0] options;
    logic [4:0] test_select;
    logic is_relative;
    logic disp_negative;
  } branch_req_t;

  typedef struct packed {
    logic valid;
    logic taken;
    logic predict_taken;
    logic [6:0] arch_bit;
  } branch_res_t;

  typedef struct packed {
    logic valid;
    logic [1:0] kind; // 0 int record, 1 float record, 2 compare, 3 field/bit write
    logic [2:0] field;
    logic is_float;
    logic is_signed;
    logic [31:0] a;
    logic [31:0] b;
    logic a_nan;
    logic b_nan;
    logic single_bit;
    logic [4:0] bit_sel;
    logic [3:0] wdata;
  } cond_update_t;

  // register-wide bit index to bit of a 32-bit vector (bit 0 is msb)
  function automatic logic [4:0] vec_index(input logic [4:0] sel);
    vec_index = 5'h1F - sel;
  endfunction : vec_index
endpackage : cond_select_pkg

//--- logic/branch_condition_select.sv
// condition field register with branch condition decode and static prediction
//
// What this block does
// - no hint: relative nonnegative displacement predicts fall-through
// - no hint: register-target branch predicts not taken
// - whole 5-bit select names the tested bit
// - upper three pick field, lower two pick flag
// - architected bit number is select plus 32
// - integer records to field 0, float to field 1
// - less flag set exactly when result negative
// - greater flag set when result positive, nonzero
// - zero flag set exactly when result zero
// - fourth flag copies summary overflow at completion
// - integer compares set signed or unsigned relation
// - float compares set relation, unordered on nan
// - compares and moves may overwrite fields or bits
// - options bit 4 skips test, bit 3 sense
`timescale 1ns/1ps
module branch_condition_select
  import cond_select_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // execution side
  input wire cond_update_t upd,
  input wire logic so_flag,
  input wire branch_req_t breq,
  output branch_res_t bres,
  output logic [31:0] cond_out
);
  logic [31:0] condition_field_register;
  logic summary_so;
  apb_state_t apb_st;

  // ============================================================
  // condition evaluation
  function automatic logic [3:0] int_compare(input logic [31:0] a, input logic [31:0] b,
                                             input logic sgn, input logic so);
    logic less;
    logic more;
    less = sgn ? ($signed(a) < $signed(b)) : (a < b);
    more = sgn ? ($signed(a) > $signed(b)) : (a > b);
    int_compare = {less, more, a == b, so};
  endfunction : int_compare

  // write strobe of the access phase for one register offset
  function automatic logic apb_write_hit(input logic [7:0] offset);
    apb_write_hit = psel && penable && pwrite && (paddr == offset);
  endfunction : apb_write_hit

  logic [3:0] next_nibble;
  logic [2:0] tgt_field;
  always_comb begin
    next_nibble = upd.wdata;
    tgt_field = upd.field;
    case (upd.kind)
      2'h0: begin
        tgt_field = FIELD_INT;
        // result sign vs zero
        next_nibble = int_compare(upd.a, 32'h0000_0000, 1'b1, summary_so);
      end
      2'h1: begin
        tgt_field = FIELD_FLOAT;
        next_nibble = upd.wdata;
      end
      2'h2: begin
        if (upd.is_float) begin
          if (upd.a_nan || upd.b_nan)
            next_nibble = 4'h1;
          else
            next_nibble = {int_compare(upd.a, upd.b, 1'b1, 1'b0)};
        end else begin
          next_nibble = int_compare(upd.a, upd.b, upd.is_signed, summary_so);
        end
      end
      default: next_nibble = upd.wdata;
    endcase
  end

  // ============================================================
  // condition register update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      condition_field_register <= COND_RESET;
    end else if (apb_write_hit(ADDR_COND)) begin
      condition_field_register <= pwdata;
    end else if (upd.valid) begin
      if (upd.kind == 2'h3 && upd.single_bit)
        condition_field_register[vec_index(upd.bit_sel)] <= upd.wdata[0];
      else
        condition_field_register[vec_index({tgt_field, FLAG_LESS})-:4] <= next_nibble;
    end
  end

  // summary overflow copy, sampled from so_flag every cycle unless written over apb
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summary_so <= 1'b0;
    end else if (apb_write_hit(ADDR_SUMMARY)) begin
      summary_so <= pwdata[0];
    end else begin
      summary_so <= so_flag;
    end
  end

  // ============================================================
  // branch decode
  logic tested;
  logic cond_ok;
  logic [1:0] hint;
  logic pred;
  always_comb begin
    tested = condition_field_register[vec_index(breq.test_select)];
    cond_ok = breq.options[OPT_IGNORE] ||
              (tested == breq.options[OPT_SENSE]);
    hint = {breq.options[OPT_A], breq.options[OPT_T]};
    if (breq.options[OPT_IGNORE]) begin
      hint = {breq.options[OPT_SENSE], breq.options[OPT_T]};
    end
    if (hint == HINT_NONE) begin
      pred = breq.is_relative && breq.disp_negative;
    end else if (!breq.is_relative) begin
      pred = (hint == HINT_TAKEN);
    end else begin
      pred = breq.options[OPT_T] ^ breq.disp_negative;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bres <= '0;
    end else begin
      bres.valid <= breq.valid;
      bres.taken <= breq.valid && cond_ok;
      bres.predict_taken <= breq.valid && pred;
      bres.arch_bit <= {2'h0, breq.test_select} + ARCH_BIT_OFFSET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cond_out <= COND_RESET;
    else
      cond_out <= condition_field_register;
  end

  // ============================================================
  // apb slave: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_st <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      case (apb_st)
        ST_IDLE: begin
          pready <= 1'b0;
          if (psel && !penable) begin
            apb_st <= ST_ACCESS;
            pready <= 1'b1;
            pslverr <= (paddr >= ADDR_LAST) || (paddr[1:0] != 2'h0);
            prdata <= (paddr == ADDR_COND) ? condition_field_register :
                      (paddr == ADDR_SUMMARY) ? {31'h0, summary_so} : 32'h0000_0000;
          end
        end
        ST_ACCESS: begin
          apb_st <= ST_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: apb_st <= ST_IDLE;
      endcase
    end
  end

  // ============================================================
  // checks
  a_arch_bit_offset: assert property (@(posedge pclk) disable iff (!presetn)
    breq.valid |=> bres.arch_bit == {2'h0, $past(breq.test_select)} + ARCH_BIT_OFFSET)
    else $error("arch bit offset wrong");
  a_skip_test: assert property (@(posedge pclk) disable iff (!presetn)
    breq.valid && breq.options[OPT_IGNORE] |=> bres.taken)
    else $error("ignored condition not taken");
  a_default_fall: assert property (@(posedge pclk) disable iff (!presetn)
    breq.valid && breq.is_relative && !breq.disp_negative &&
    breq.options[OPT_A:OPT_T] == 2'h0 && !breq.options[OPT_IGNORE] |=> !bres.predict_taken)
    else $error("default relative predicted taken");
  a_reg_default: assert property (@(posedge pclk) disable iff (!presetn)
    breq.valid && !breq.is_relative && breq.options[OPT_A:OPT_T] == 2'h0 &&
    !breq.options[OPT_IGNORE] |=> !bres.predict_taken)
    else $error("default register branch predicted taken");
  a_int_field: assert property (@(posedge pclk) disable iff (!presetn)
    upd.valid && upd.kind == 2'h0 && !(psel && penable && pwrite) |=>
    condition_field_register[31] == $past(upd.a[31]))
    else $error("record less flag wrong");
  a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
    upd.valid && upd.kind == 2'h0 && !(psel && penable && pwrite) |=>
    condition_field_register[29] == ($past(upd.a) == 32'h0))
    else $error("record zero flag wrong");
  a_greater_flag: assert property (@(posedge pclk) disable iff (!presetn)
    upd.valid && upd.kind == 2'h0 && !(psel && penable && pwrite) |=>
    condition_field_register[30] == (!$past(upd.a[31]) && $past(upd.a) != 32'h0))
    else $error("record greater flag wrong");
  a_nan_flag: assert property (@(posedge pclk) disable iff (!presetn)
    upd.valid && upd.kind == 2'h2 && upd.is_float && upd.a_nan &&
    !(psel && penable && pwrite) |=>
    condition_field_register[vec_index({$past(upd.field), FLAG_OVER})])
    else $error("unordered flag not set");

  // ============================================================
  // handshake and update sequences
  logic wr_any;
  assign wr_any = psel && penable && pwrite;

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_apb_access;
    psel && penable && pready;
  endsequence

  sequence s_br_issue;
    breq.valid;
  endsequence

  sequence s_rec_update;
    upd.valid && upd.kind == 2'h0 && !wr_any;
  endsequence

  // ============================================================
  // bus handshake checks
  a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup
    |=> pready)
    else $error("no ready after setup");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready
    |=> !pready)
    else $error("ready longer than one cycle");

  a_range_error: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup && paddr >= ADDR_LAST
    |=> pready && pslverr)
    else $error("out of range access not refused");

  a_legal_access: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup && paddr[1:0] == 2'h0 && paddr < ADDR_LAST
    |=> !pslverr)
    else $error("legal access refused");

  a_read_cond: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup && !pwrite && paddr == ADDR_COND
    |=> prdata == $past(condition_field_register))
    else $error("condition read data wrong");

  a_write_cond: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_access && pwrite && paddr == ADDR_COND
    |=> condition_field_register == $past(pwdata))
    else $error("condition write lost");

  // ============================================================
  // branch result and condition copy checks
  a_test_bit: assert property (@(posedge pclk) disable iff (!presetn)
    s_br_issue && !breq.options[OPT_IGNORE]
    |=> bres.taken == ($past(condition_field_register[5'h1F - breq.test_select]) ==
                       $past(breq.options[OPT_SENSE])))
    else $error("tested bit wrong");

  a_field_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_br_issue && !breq.options[OPT_IGNORE]
    |=> bres.taken == ($past(condition_field_register[5'h1F - {breq.test_select[4:2], 2'h0} -
                       breq.test_select[1:0]]) == $past(breq.options[OPT_SENSE])))
    else $error("field and flag split wrong");

  a_reg_hint: assert property (@(posedge pclk) disable iff (!presetn)
    s_br_issue && !breq.is_relative && !breq.options[OPT_IGNORE] &&
    breq.options[OPT_A:OPT_T] == HINT_TAKEN
    |=> bres.predict_taken)
    else $error("register hint taken ignored");

  a_result_valid: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> bres.valid == $past(breq.valid))
    else $error("branch result valid wrong");

  a_cond_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> cond_out == $past(condition_field_register))
    else $error("condition copy wrong");

  // ============================================================
  // record, compare, field/bit write and overflow copy checks
  a_less_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_rec_update
    |=> condition_field_register[31] == $past($signed(upd.a) < 0))
    else $error("record less flag wrong");

  a_so_record: assert property (@(posedge pclk) disable iff (!presetn)
    s_rec_update
    |=> condition_field_register[28] == $past(summary_so))
    else $error("record overflow copy wrong");

  a_so_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_any && paddr == ADDR_SUMMARY)
    |=> summary_so == $past(so_flag))
    else $error("overflow copy stale");

  a_float_field: assert property (@(posedge pclk) disable iff (!presetn)
    upd.valid && upd.kind == 2'h1 && !wr_any
    |=> condition_field_register[27:24] == $past(upd.wdata))
    else $error("float record field wrong");

  a_cmp_unsigned: assert property (@(posedge pclk) disable iff (!presetn)
    upd.valid && upd.kind == 2'h2 && !upd.is_float && !upd.is_signed && !wr_any
    |=> condition_field_register[5'h1F - {$past(upd.field), 2'h0}] == $past(upd.a < upd.b))
    else $error("unsigned compare wrong");

  a_cmp_signed: assert property (@(posedge pclk) disable iff (!presetn)
    upd.valid && upd.kind == 2'h2 && !upd.is_float && upd.is_signed && !wr_any
    |=> condition_field_register[5'h1E - {$past(upd.field), 2'h0}] ==
        $past($signed(upd.a) > $signed(upd.b)))
    else $error("signed compare wrong");

  a_float_order: assert property (@(posedge pclk) disable iff (!presetn)
    upd.valid && upd.kind == 2'h2 && upd.is_float && !upd.a_nan && !upd.b_nan && !wr_any
    |=> !condition_field_register[5'h1C - {$past(upd.field), 2'h0}])
    else $error("ordered compare flagged unordered");

  a_bit_write: assert property (@(posedge pclk) disable iff (!presetn)
    upd.valid && upd.kind == 2'h3 && upd.single_bit && !wr_any
    |=> condition_field_register[5'h1F - $past(upd.bit_sel)] == $past(upd.wdata[0]))
    else $error("single bit write wrong");

  a_field_write: assert property (@(posedge pclk) disable iff (!presetn)
    upd.valid && upd.kind == 2'h3 && !upd.single_bit && !wr_any
    |=> condition_field_register[5'h1F - {$past(upd.field), 2'h0} -: 4] == $past(upd.wdata))
    else $error("field write wrong");
endmodule : branch_condition_select

//--- testbench/exec_partner.sv
// execution-side model driving record updates, overflow copy and branches
`timescale 1ns/1ps
module exec_partner
  import cond_select_pkg::*;
(
  // clock
  input wire logic pclk,
  // towards the block
  output cond_update_t upd,
  output logic so_flag,
  output branch_req_t breq
);
  initial begin
    upd = '0;
    so_flag = 1'b0;
    breq = '0;
  end

  // on release valid drops and the a operand is inverted, other fields are held
  task automatic send_upd(input cond_update_t u);
    @(posedge pclk);
    upd <= u;
    @(posedge pclk);
    upd.valid <= 1'b0;
    upd.a <= ~u.a;
  endtask : send_upd

  // hint: 0 none, 1 likely taken, 2 likely not taken
  task automatic send_br(input logic [4:0] sel, input logic [1:0] ign_sense, input logic rel,
                         input logic neg, input int hint);
    branch_req_t r;
    r = '{1'b1, {ign_sense, 1'b1, HINT_NONE}, sel, rel, neg};
    if (hint == 1) r.options[1:0] = rel ? {1'b1, ~neg} : HINT_TAKEN;
    if (hint == 2) r.options[1:0] = rel ? {1'b1, neg} : HINT_NOT_TAKEN;
    if (ign_sense[1]) r.options[3] = r.options[1];
    @(posedge pclk);
    breq <= r;
    @(posedge pclk);
    breq.valid <= 1'b0;
    breq.test_select <= ~sel;
  endtask : send_br

  task automatic set_so(input logic v);
    @(posedge pclk);
    so_flag <= v;
  endtask : set_so
endmodule : exec_partner

//--- testbench/branch_condition_select_test.sv
// self-checking bench for the condition register and branch decode
`timescale 1ns/1ps
module branch_condition_select_test
  import cond_select_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, so_flag, err, is_less, is_more;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cond_out, model, rd, rng, v;
  cond_update_t upd, u;
  branch_req_t breq;
  branch_res_t bres, eb;
  int num_errors, tests_run;

  branch_condition_select uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .upd(upd), .so_flag(so_flag), .breq(breq),
    .bres(bres), .cond_out(cond_out));
  exec_partner p (.pclk(pclk), .upd(upd), .so_flag(so_flag), .breq(breq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_br(input branch_res_t got, input branch_res_t exp);
    chk({22'h0, got}, {22'h0, exp});
  endtask : chk_br

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic conclude();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    #50000;
    num_errors++;
    conclude();
  end

  // ==========================================
  // main sequence
  initial begin
    rng = 32'h0173EF8E;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    chk(cond_out, COND_RESET);
    chk_br(bres, '0);
    presetn <= 1'b1;
    model = xs();
    apb(1'b1, ADDR_COND, model);
    apb(1'b1, ADDR_LAST, ~model);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h02, ~model);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, ADDR_COND, 32'h0);
    chk(rd, model);
    p.set_so(1'b1);
    apb(1'b0, ADDR_SUMMARY, 32'h0);
    chk(rd, 32'h1);
    for (int k = 0; k < 48; k++) begin
      v = xs();
      u = '0;
      u.valid = 1'b1;
      u.kind = k[1:0];
      {u.field, u.is_float, u.is_signed, u.a_nan} = v[5:0];
      {u.single_bit, u.bit_sel, u.wdata} = v[15:6];
      u.a = (k < 8) ? 32'h0 : xs();
      u.b = v[16] ? u.a : xs();
      if (u.is_float) u.b = u.a & 32'h3FFFFFFF;
      if (u.is_float) u.a = u.b;
      is_less = u.is_signed ? ($signed(u.a) < $signed(u.b)) : (u.a < u.b);
      is_more = u.is_signed ? ($signed(u.a) > $signed(u.b)) : (u.a > u.b);
      p.set_so(v[17]);
      repeat (2) @(posedge pclk);
      p.send_upd(u);
      case (u.kind)
        2'h0: model[31:28] = {u.a[31], !u.a[31] && u.a != 0, u.a == 0, v[17]};
        2'h1: model[27:24] = u.wdata;
        2'h2: model[31 - 4 * u.field -: 4] = u.is_float ? (u.a_nan ? 4'h1 : 4'h2) :
          {is_less, is_more, u.a == u.b, v[17]};
        default: if (u.single_bit) model[31 - u.bit_sel] = u.wdata[0];
          else model[31 - 4 * u.field -: 4] = u.wdata;
      endcase
      repeat (3) @(posedge pclk);
      chk(cond_out, model);
    end
    for (int s = 0; s < 32; s++) begin
      v = xs();
      p.send_br(s[4:0], v[1:0], v[2], v[3], s % 3);
      #1;
      eb.valid = 1'b1;
      eb.taken = v[1] | (model[31 - (4 * s[4:2] + s[1:0])] == v[0]);
      eb.predict_taken = (s % 3 == 1) | (s % 3 == 0 && v[2] && v[3]);
      eb.arch_bit = {2'h0, s[4:0]} + ARCH_BIT_OFFSET;
      chk_br(bres, eb);
    end
    conclude();
  end
endmodule : branch_condition_select_test
